// *** bench/cxf_coproc_model.sv ***
// Purpose: Coprocessor model driving the busy and error lines.
// Assumes: The bench starts a busy period and sets the error level.
// Notes:   Lines move on the rising edge; the block synchronises them anyway.
`timescale 1ns/1ns
module cxf_coproc_model (
   input  wire logic       clk_sys,
   input  wire logic       start,
   input  wire logic [7:0] busy_len,
   input  wire logic       err_set,
   output logic            coproc_busy_n,
   output logic            coproc_error_n
);
   logic [7:0] cnt_q = 8'h00;
   initial begin
      coproc_busy_n = 1'h1;
      coproc_error_n = 1'h1;
   end
   always @(posedge clk_sys) begin
      if (start) begin
         cnt_q <= busy_len;
         coproc_busy_n <= (busy_len == 8'h00);
      end else begin
         if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
         end
         coproc_busy_n <= (cnt_q <= 8'h01);
      end
      coproc_error_n <= !err_set;
   end
endmodule

// *** bench/cxf_core_tb_top.sv ***
// Purpose: Self-checking bench for the execution-control block.
// Assumes: Zero-wait APB slave; shortened initialisation count.
// Notes:   Interrupts are counted by a monitor so none is missed.
`timescale 1ns/1ns
module cxf_core_tb_top;
   import cxf_pkg::*;
   localparam int INIT = 4;
   localparam logic [34:0] TV [7] = '{{CXF_OP_ADD, 16'hFFFF, 16'h0001},
      {CXF_OP_ADD, 16'h7FFF, 16'h0001}, {CXF_OP_SUB, 16'h0000, 16'h0001},
      {CXF_OP_SUB, 16'h8000, 16'h0001}, {CXF_OP_AND, 16'h00F0, 16'h0F0F},
      {CXF_OP_OR, 16'h8000, 16'h0003}, {CXF_OP_XOR, 16'h00F0, 16'h0001}};
   logic         clk_sys = 1'h0;
   logic         rst = 1'h1;
   logic         psel = 1'h0;
   logic         penable = 1'h0;
   logic         pwrite = 1'h0;
   logic [11:0]  paddr = 12'h000;
   logic [31:0]  pwdata = 32'h0;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic         coproc_busy_n;
   logic         coproc_error_n;
   logic         maskable_int_req = 1'h0;
   logic         nmi_req = 1'h0;
   cxf_pins_type pins;
   logic         proc_clk_en;
   logic         int_taken;
   logic [7:0]   int_vector;
   logic [15:0]  index_step;
   logic         first_fetch;
   logic         cp_start = 1'h0;
   logic [7:0]   cp_len = 8'h00;
   logic         cp_err = 1'h0;
   logic [31:0]  rd;
   logic         er;
   logic [15:0]  exp_f;
   logic [15:0]  mask;
   logic [31:0]  exp_v;
   int           n_errors = 0;
   int           n_tests = 0;
   int           n_int = 0;

   always #4 clk_sys = ~clk_sys;

   cxf_core #(.INIT_CYCLES(INIT)) dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .coproc_busy_n(coproc_busy_n),
      .coproc_error_n(coproc_error_n), .maskable_int_req(maskable_int_req),
      .nmi_req(nmi_req), .pins(pins), .proc_clk_en(proc_clk_en), .int_taken(int_taken),
      .int_vector(int_vector), .index_step(index_step), .first_fetch(first_fetch));

   cxf_coproc_model partner (.clk_sys(clk_sys), .start(cp_start), .busy_len(cp_len),
      .err_set(cp_err), .coproc_busy_n(coproc_busy_n), .coproc_error_n(coproc_error_n));

   always @(posedge clk_sys) begin
      if (int_taken === 1'h1) begin
         n_int++;
      end
   end

   task results;
      if (n_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task tmo(input string msg);
      n_errors++;
      $display("CHECK FAILED t=%0t timeout %s", $time, msg);
      results();
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (pready !== 1'h1 && i < 20);
      if (pready !== 1'h1) tmo("apb");
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task rchk(input logic [11:0] a, input logic [31:0] exp, input string msg);
      apb(1'h0, a, pwdata);
      chk(rd, exp, msg);
   endtask

   task wait_int(input logic [7:0] v, input string msg);
      int i;
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (int_taken !== 1'h1 && i < 40);
      if (int_taken !== 1'h1) tmo(msg);
      chk(int_vector, v, msg);
   endtask

   task do_reset(input int n);
      int k;
      @(posedge clk_sys);
      rst <= 1'h1;
      repeat (n) @(posedge clk_sys);
      #1;
      chk(pins, {2'h3, 1'h1, 24'hFFFFFF, 1'h1, 1'h1, 4'h0}, "reset pins");
      chk(proc_clk_en, 1'h0, "phase in reset");
      @(posedge clk_sys);
      rst <= 1'h0;
      k = 0;
      do begin
         @(posedge clk_sys);
         #1;
         k++;
         chk(proc_clk_en, k[0], "divider");
      end while (first_fetch !== 1'h1 && k < 100);
      chk(k, INIT, "init length");
      chk(pins.addr, 24'hFFFFF0, "fetch addr");
   endtask

   task cp_busy(input logic [7:0] len);
      @(posedge clk_sys);
      cp_start <= 1'h1;
      cp_len <= len;
      @(posedge clk_sys);
      cp_start <= 1'h0;
   endtask

   initial begin
      int i;
      logic [2:0] c;
      int k;
      do_reset(12);
      rchk(CXF_ADDR_FLAGS, 32'h2, "flags reset");
      apb(1'h1, CXF_ADDR_FLAGS, 32'h0000FEFF);
      rchk(CXF_ADDR_FLAGS, (32'h0000FEFF & CXF_FLAGS_WMASK) | CXF_FLAGS_RESET, "mask");
      apb(1'h0, 12'h020, 32'h0);
      chk(er, 1'h1, "unmapped");
      apb(1'h1, CXF_ADDR_FLAGS, 32'h0);
      for (i = 0; i < 7; i++) begin
         exp_v = 32'h0;
         apb(1'h1, CXF_ADDR_OPERAND, {TV[i][15:0], TV[i][31:16]});
         apb(1'h1, CXF_ADDR_EXEC, {25'h0, TV[i][34:32], 4'h1});
         case (TV[i][34:32])
            CXF_OP_ADD: exp_v = TV[i][31:16] + TV[i][15:0];
            CXF_OP_SUB: exp_v = TV[i][31:16] - TV[i][15:0];
            CXF_OP_AND: exp_v = TV[i][31:16] & TV[i][15:0];
            CXF_OP_OR: exp_v = TV[i][31:16] | TV[i][15:0];
            default: exp_v = TV[i][31:16] ^ TV[i][15:0];
         endcase
         rchk(CXF_ADDR_RESULT, {16'h0, exp_v[15:0]}, "result");
         mask = (i < 4) ? 16'h08D7 : 16'h00C6;
         apb(1'h0, CXF_ADDR_FLAGS, pwdata);
         // Every arithmetic vector carries or borrows out of the low nibble.
         exp_f = CXF_FLAGS_RESET;
         exp_f[CXF_BIT_CARRY] = (i < 4) && exp_v[16];
         exp_f[CXF_BIT_PARITY] = ~^exp_v[7:0];
         exp_f[CXF_BIT_AUX] = (i < 4);
         exp_f[CXF_BIT_ZERO] = (exp_v[15:0] == 16'h0000);
         exp_f[CXF_BIT_SIGN] = exp_v[15];
         exp_f[CXF_BIT_OVF] = (i == 1 || i == 3);
         chk(rd[15:0] & mask, exp_f & mask, "flags");
      end
      for (i = 0; i < 2; i++) begin
         c = i ? CXF_CMD_ESC : CXF_CMD_WAIT;
         cp_busy(8'h28);
         repeat (4) @(posedge clk_sys);
         apb(1'h1, CXF_ADDR_EXEC, {29'h0, c});
         apb(1'h0, CXF_ADDR_STATUS, pwdata);
         chk(rd[3:2], {i[0], 1'h1}, "stalled");
         n_int = 0;
         @(posedge clk_sys);
         nmi_req <= 1'h1;
         wait_int(CXF_VEC_NMI, "nmi in stall");
         nmi_req <= 1'h0;
         rd = 32'h4;
         k = 0;
         while (rd[2] === 1'h1 && k < 200) begin
            apb(1'h0, CXF_ADDR_STATUS, pwdata);
            k++;
            if (rd[2] === 1'h0) chk(coproc_busy_n, 1'h1, "early resume");
         end
         if (rd[2] !== 1'h0) tmo("stall release");
         cp_err <= 1'h1;
         repeat (4) @(posedge clk_sys);
         n_int = 0;
         apb(1'h1, CXF_ADDR_EXEC, {29'h0, c});
         wait_int(CXF_VEC_COPROC, "error int");
         cp_err <= 1'h0;
      end
      apb(1'h1, CXF_ADDR_FLAGS, 32'h00000100);
      n_int = 0;
      apb(1'h1, CXF_ADDR_EXEC, {29'h0, CXF_CMD_PLAIN});
      wait_int(CXF_VEC_STEP, "step int");
      apb(1'h0, CXF_ADDR_FLAGS, pwdata);
      chk(rd[CXF_BIT_STEP], 1'h0, "step cleared");
      apb(1'h1, CXF_ADDR_FLAGS, 32'h0);
      n_int = 0;
      maskable_int_req <= 1'h1;
      apb(1'h1, CXF_ADDR_EXEC, 32'h00004005);
      repeat (20) @(posedge clk_sys);
      chk(n_int, 0, "masked");
      maskable_int_req <= 1'h0;
      apb(1'h1, CXF_ADDR_FLAGS, 32'h00000200);
      apb(1'h1, CXF_ADDR_EXEC, 32'h00004005);
      n_int = 0;
      maskable_int_req <= 1'h1;
      wait_int(8'h40, "maskable");
      maskable_int_req <= 1'h0;
      for (i = 0; i < 2; i++) begin
         apb(1'h1, CXF_ADDR_FLAGS, i ? 32'h00000400 : 32'h0);
         apb(1'h1, CXF_ADDR_EXEC, {29'h0, CXF_CMD_STRING});
         repeat (3) @(posedge clk_sys);
         chk(index_step, i ? 16'hFFFF : 16'h0001, "index step");
      end
      do_reset(17);
      rchk(CXF_ADDR_FLAGS, 32'h2, "flags after reset");
      results();
   end
endmodule

// *** rtl/cxf_core.sv ***
// Purpose: Reset sequencing, processor-clock phase, coprocessor wait/error and flags word.
// Assumes: APB slave, pready always high; rst synchronous, active high.
// Notes:   Instructions are issued by software writes to the execute register.
`timescale 1ns/1ns
module cxf_core
   import cxf_pkg::*;
#(
   parameter int INIT_CYCLES = CXF_INIT_CYCLES
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         coproc_busy_n,
   input  wire logic         coproc_error_n,
   input  wire logic         maskable_int_req,
   input  wire logic         nmi_req,
   output cxf_pins_type      pins,
   output logic              proc_clk_en,
   output logic              int_taken,
   output logic      [7:0]   int_vector,
   output logic      [15:0]  index_step,
   output logic              first_fetch
);
   logic [15:0]   flags_q;
   logic [15:0]   result_q;
   logic [15:0]   opa_q;
   logic [15:0]   opb_q;
   logic          phase_q;
   logic [5:0]    init_cnt_q;
   cxf_state_type state_q;
   logic [1:0]    busy_sync_q;
   logic [1:0]    err_sync_q;
   logic          nmi_prev_q;
   logic          step_pend_q;
   logic          stalled_cmd_esc_q;
   logic          wr_acc;
   logic          rd_acc;
   logic          exec_wr;
   logic [2:0]    cmd;
   logic [2:0]    alu_op;
   logic [16:0]   sum;
   logic [4:0]    nib;
   logic [15:0]   res;
   logic          c_out;
   logic          a_out;
   logic          v_out;
   logic          busy;
   logic          err;
   logic          nmi_edge;
   logic          mask_int;
   logic          instr_done;

   assign pready  = 1'b1;
   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & penable & ~pwrite;
   assign exec_wr = wr_acc && paddr == CXF_ADDR_EXEC && state_q != CXF_INIT;
   assign cmd     = pwdata[2:0];
   assign alu_op  = pwdata[6:4];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busy_sync_q <= 2'h3;
         err_sync_q  <= 2'h3;
      end else begin
         busy_sync_q <= {busy_sync_q[0], coproc_busy_n};
         err_sync_q  <= {err_sync_q[0], coproc_error_n};
      end
   end
   assign busy = ~busy_sync_q[1];
   assign err  = ~err_sync_q[1];

   // phase divider
   // Reset holds the divider, so the phase after release is fixed; with an
   // asynchronous rise the first period is indeterminate, which is tolerated.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= ~phase_q;
      end
   end
   assign proc_clk_en = phase_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         init_cnt_q <= '0;
      end else if (state_q == CXF_INIT) begin
         init_cnt_q <= init_cnt_q + 6'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         nmi_prev_q <= 1'b0;
      end else begin
         nmi_prev_q <= nmi_req;
      end
   end
   assign nmi_edge = nmi_req & ~nmi_prev_q;
   assign mask_int = maskable_int_req & flags_q[CXF_BIT_INTEN];

   always_comb begin
      sum   = '0;
      nib   = '0;
      res   = '0;
      c_out = 1'b0;
      a_out = 1'b0;
      v_out = 1'b0;
      case (alu_op)
         CXF_OP_ADD: begin
            sum   = {1'b0, opa_q} + {1'b0, opb_q};
            nib   = {1'b0, opa_q[3:0]} + {1'b0, opb_q[3:0]};
            res   = sum[15:0];
            c_out = sum[16];
            a_out = nib[4];
            v_out = (opa_q[15] == opb_q[15]) && (res[15] != opa_q[15]);
         end
         CXF_OP_SUB: begin
            sum   = {1'b0, opa_q} - {1'b0, opb_q};
            nib   = {1'b0, opa_q[3:0]} - {1'b0, opb_q[3:0]};
            res   = sum[15:0];
            c_out = sum[16];
            a_out = nib[4];
            v_out = (opa_q[15] != opb_q[15]) && (res[15] != opa_q[15]);
         end
         CXF_OP_AND: res = opa_q & opb_q;
         CXF_OP_OR:  res = opa_q | opb_q;
         CXF_OP_XOR: res = opa_q ^ opb_q;
         default:    res = opa_q;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q           <= CXF_INIT;
         stalled_cmd_esc_q <= 1'b0;
      end else begin
         case (state_q)
            CXF_INIT: begin
               if (init_cnt_q == 6'(INIT_CYCLES - 1)) begin
                  state_q <= CXF_RUN;
               end
            end
            CXF_RUN: begin
               if (exec_wr && (cmd == CXF_CMD_WAIT || cmd == CXF_CMD_ESC) && busy) begin
                  state_q           <= CXF_STALL;
                  stalled_cmd_esc_q <= cmd == CXF_CMD_ESC;
               end
            end
            CXF_STALL: begin
               if (!busy) begin
                  state_q <= CXF_RUN;
               end
            end
            default: state_q <= CXF_INIT;
         endcase
      end
   end

   // An instruction completes on its write, or when a stall is released.
   assign instr_done = (state_q == CXF_RUN && exec_wr && cmd != CXF_CMD_NONE &&
                        !((cmd == CXF_CMD_WAIT || cmd == CXF_CMD_ESC) && busy)) ||
                       (state_q == CXF_STALL && !busy);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         int_taken   <= 1'b0;
         int_vector  <= '0;
         step_pend_q <= 1'b0;
      end else begin
         int_taken   <= 1'b0;
         step_pend_q <= instr_done & flags_q[CXF_BIT_STEP];
         if (state_q != CXF_INIT) begin
            if (nmi_edge) begin
               int_taken  <= 1'b1;
               int_vector <= CXF_VEC_NMI;
            end else if (instr_done && err &&
                         (state_q == CXF_STALL || cmd == CXF_CMD_WAIT ||
                          cmd == CXF_CMD_ESC)) begin
               int_taken  <= 1'b1;
               int_vector <= CXF_VEC_COPROC;
            end else if (step_pend_q) begin
               int_taken  <= 1'b1;
               int_vector <= CXF_VEC_STEP;
            end else if (mask_int) begin
               int_taken  <= 1'b1;
               int_vector <= pwdata[15:8];
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flags_q  <= CXF_FLAGS_RESET;
         result_q <= '0;
      end else begin
         if (wr_acc && paddr == CXF_ADDR_FLAGS) begin
            flags_q <= (pwdata[15:0] & CXF_FLAGS_WMASK) | CXF_FLAGS_RESET;
         end else if (exec_wr && cmd == CXF_CMD_ALU) begin
            result_q                <= res;
            flags_q[CXF_BIT_CARRY]  <= c_out;
            flags_q[CXF_BIT_PARITY] <= ~^res[7:0];
            flags_q[CXF_BIT_AUX]    <= a_out;
            flags_q[CXF_BIT_ZERO]   <= res == 16'h0000;
            flags_q[CXF_BIT_SIGN]   <= res[15];
            flags_q[CXF_BIT_OVF]    <= v_out;
         end
         if (step_pend_q && !nmi_edge) begin
            flags_q[CXF_BIT_STEP] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         opa_q <= '0;
         opb_q <= '0;
      end else if (wr_acc && paddr == CXF_ADDR_OPERAND) begin
         opa_q <= pwdata[15:0];
         opb_q <= pwdata[31:16];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         index_step <= '0;
      end else if (exec_wr && cmd == CXF_CMD_STRING) begin
         index_step <= flags_q[CXF_BIT_DIR] ? 16'hFFFF : 16'h0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pins.cycle_status        <= 2'h3;
         pins.operand_ack_n       <= 1'b1;
         pins.addr                <= 24'hFFFFFF;
         pins.high_byte_enable_n  <= 1'b1;
         pins.lock_n              <= 1'b1;
         pins.mem_io_sel          <= 1'b0;
         pins.fetch_or_ack_select <= 1'b0;
         pins.hold_ack            <= 1'b0;
         pins.data_oe             <= 1'b0;
         first_fetch              <= 1'b0;
      end else begin
         first_fetch <= 1'b0;
         if (state_q == CXF_INIT && init_cnt_q == 6'(INIT_CYCLES - 1)) begin
            first_fetch              <= 1'b1;
            pins.cycle_status        <= 2'h2;
            pins.addr                <= 24'hFFFFF0;
            pins.high_byte_enable_n  <= 1'b0;
            pins.mem_io_sel          <= 1'b1;
            pins.fetch_or_ack_select <= 1'b1;
         end else if (first_fetch) begin
            pins.cycle_status <= 2'h3;
         end
      end
   end

   always_comb begin
      prdata  = '0;
      pslverr = 1'b0;
      if (rd_acc) begin
         case (paddr)
            CXF_ADDR_FLAGS:   prdata = {16'h0000, flags_q};
            CXF_ADDR_STATUS:  prdata = {28'h0000000, stalled_cmd_esc_q,
                                        state_q == CXF_STALL, err, busy};
            CXF_ADDR_OPERAND: prdata = {opb_q, opa_q};
            CXF_ADDR_RESULT:  prdata = {16'h0000, result_q};
            CXF_ADDR_EXEC:    prdata = '0;
            default:          pslverr = 1'b1;
         endcase
      end else if (psel && penable && !(paddr inside {CXF_ADDR_FLAGS, CXF_ADDR_EXEC,
                                        CXF_ADDR_OPERAND})) begin
         pslverr = 1'b1;
      end
   end

   // Assertions.
   property p_stall_busy;
      @(posedge clk_sys) disable iff (rst)
         (state_q == CXF_STALL && busy) |=> state_q == CXF_STALL;
   endproperty
   a_stall_busy: assert property (p_stall_busy) else $error("stall released early");

   property p_nmi_vec;
      @(posedge clk_sys) disable iff (rst)
         (nmi_edge && state_q != CXF_INIT) |=> int_taken && int_vector == 8'h02;
   endproperty
   a_nmi_vec: assert property (p_nmi_vec) else $error("nmi not vector 2");

   property p_mask;
      @(posedge clk_sys) disable iff (rst)
         int_taken && int_vector != CXF_VEC_NMI && int_vector != CXF_VEC_STEP &&
         int_vector != CXF_VEC_COPROC |-> $past(flags_q[CXF_BIT_INTEN]);
   endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt taken");

   property p_zero;
      @(posedge clk_sys) disable iff (rst)
         (exec_wr && cmd == CXF_CMD_ALU && !(wr_acc && paddr == CXF_ADDR_FLAGS))
         |=> flags_q[CXF_BIT_ZERO] == (result_q == 16'h0000)
          && flags_q[CXF_BIT_SIGN] == result_q[15];
   endproperty
   a_zero: assert property (p_zero) else $error("zero or sign flag wrong");

   property p_parity;
      @(posedge clk_sys) disable iff (rst)
         (exec_wr && cmd == CXF_CMD_ALU) |=> flags_q[CXF_BIT_PARITY] == ~^result_q[7:0];
   endproperty
   a_parity: assert property (p_parity) else $error("parity flag wrong");

   property p_phase;
      @(posedge clk_sys) disable iff (rst)
         proc_clk_en |=> !proc_clk_en ##1 proc_clk_en;
   endproperty
   a_phase: assert property (p_phase) else $error("divider not by two");

   property p_reset_pins;
      @(posedge clk_sys) rst |=> pins.addr == 24'hFFFFFF && pins.lock_n && !pins.hold_ack
                                 && !pins.data_oe && pins.cycle_status == 2'h3;
   endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("reset pin state wrong");

   // Saturating count of cycles since reset release, so the first fetch can be
   // checked against the initialisation length whatever its value.
   logic [6:0] since_rst_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         since_rst_q <= '0;
      end else if (since_rst_q != 7'h7F) begin
         since_rst_q <= since_rst_q + 7'h01;
      end
   end

   property p_init;
      @(posedge clk_sys) disable iff (rst)
         first_fetch |-> since_rst_q == 7'(INIT_CYCLES);
   endproperty
   a_init: assert property (p_init) else $error("fetch too soon after reset");

   property p_sync;
      @(posedge clk_sys) disable iff (rst)
         !coproc_busy_n && busy_sync_q == 2'h3 |-> ##2 busy;
   endproperty
   a_sync: assert property (p_sync) else $error("busy sync wrong");
endmodule

// *** rtl/cxf_pkg.sv ***
// Purpose: Shared constants and types for the execution-control block.
// Assumes: 32-bit APB register access, one system clock.
// Notes:   Register offsets are byte addresses.
package cxf_pkg;
   localparam logic [11:0] CXF_ADDR_FLAGS    = 12'h000;
   localparam logic [11:0] CXF_ADDR_EXEC     = 12'h004;
   localparam logic [11:0] CXF_ADDR_STATUS   = 12'h008;
   localparam logic [11:0] CXF_ADDR_OPERAND  = 12'h00C;
   localparam logic [11:0] CXF_ADDR_RESULT   = 12'h010;
   localparam logic [15:0] CXF_FLAGS_RESET   = 16'h0002;
   localparam logic [15:0] CXF_FLAGS_WMASK   = 16'h0FD5;
   localparam int          CXF_BIT_CARRY     = 0;
   localparam int          CXF_BIT_PARITY    = 2;
   localparam int          CXF_BIT_AUX       = 4;
   localparam int          CXF_BIT_ZERO      = 6;
   localparam int          CXF_BIT_SIGN      = 7;
   localparam int          CXF_BIT_STEP      = 8;
   localparam int          CXF_BIT_INTEN     = 9;
   localparam int          CXF_BIT_DIR       = 10;
   localparam int          CXF_BIT_OVF       = 11;
   localparam int          CXF_RESET_MIN_CYC = 16;
   localparam int          CXF_INIT_CYCLES   = 50;
   localparam logic [7:0]  CXF_VEC_NMI       = 8'h02;
   localparam logic [7:0]  CXF_VEC_STEP      = 8'h01;
   localparam logic [7:0]  CXF_VEC_COPROC    = 8'h10;
   localparam logic [2:0]  CXF_OP_ADD        = 3'h0;
   localparam logic [2:0]  CXF_OP_SUB        = 3'h1;
   localparam logic [2:0]  CXF_OP_AND        = 3'h2;
   localparam logic [2:0]  CXF_OP_OR         = 3'h3;
   localparam logic [2:0]  CXF_OP_XOR        = 3'h4;
   localparam logic [2:0]  CXF_CMD_NONE      = 3'h0;
   localparam logic [2:0]  CXF_CMD_ALU       = 3'h1;
   localparam logic [2:0]  CXF_CMD_WAIT      = 3'h2;
   localparam logic [2:0]  CXF_CMD_ESC       = 3'h3;
   localparam logic [2:0]  CXF_CMD_STRING    = 3'h4;
   localparam logic [2:0]  CXF_CMD_PLAIN     = 3'h5;

   typedef enum {CXF_INIT, CXF_RUN, CXF_STALL} cxf_state_type;

   typedef struct packed {
      logic [1:0]  cycle_status;
      logic        operand_ack_n;
      logic [23:0] addr;
      logic        high_byte_enable_n;
      logic        lock_n;
      logic        mem_io_sel;
      logic        fetch_or_ack_select;
      logic        hold_ack;
      logic        data_oe;
   } cxf_pins_type;
endpackage
